/* File: design/mac_pkg.sv */
// Purpose: shared constants, operation codes and saturation helpers
//          for the fractional multiply-accumulate/subtract datapath.
// Assumes: two's complement Q15, Q31 and Q63 fractional formats.
// Notes:   accumulators are 64 bits wide; general-register words 32 bits.
package mac_pkg;

  // ==========================================================
  // widths and field positions
  localparam int WORD_WIDTH = 32;
  localparam int HALF_WIDTH = 16;
  localparam int ACC_WIDTH = 64;
  localparam int GPR_INDEX_WIDTH = 5;
  localparam int UPPER_HALF_LSB = 16;
  localparam int ACC_SEL_WIDTH_DEFAULT = 2;

  // ==========================================================
  // fractional limits and reset values
  localparam logic [15:0] Q15_MINUS_ONE = 16'h8000;
  localparam logic [31:0] Q31_MINUS_ONE = 32'h80000000;
  localparam logic [31:0] Q31_MAX = 32'h7FFFFFFF;
  localparam logic [63:0] Q31_MAX_EXT = 64'h000000007FFFFFFF;
  localparam logic [63:0] Q31_MIN_EXT = 64'hFFFFFFFF80000000;
  localparam logic [63:0] Q63_MAX = 64'h7FFFFFFFFFFFFFFF;
  localparam logic [63:0] Q63_MIN = 64'h8000000000000000;
  localparam logic [15:0] H16_MAX = 16'h7FFF;
  localparam logic [15:0] H16_MIN = 16'h8000;
  localparam logic [63:0] ACC_RESET = 64'h0000000000000000;
  localparam logic [31:0] GPR_DATA_RESET = 32'h00000000;

  // ==========================================================
  // timing: results appear this many cycles after the operation is taken
  localparam int RESULT_LATENCY = 1;

  // ==========================================================
  // operation codes
  typedef enum logic [3:0] {
    q15_dot_product_subtract,
    crossed_q15_dot_subtract,
    crossed_q15_dot_subtract_sat,
    complex_multiply_step,
    long_fractional_mac_sat,
    long_fractional_msub_sat,
    fractional_mac_upper,
    fractional_mac_lower,
    fractional_mac_upper_acc_sat,
    fractional_mac_lower_acc_sat,
    paired_halfword_multiply,
    paired_halfword_multiply_sat
  } op_type;

  // ==========================================================
  // saturation helpers on a 65-bit signed intermediate
  function automatic logic [63:0] sat_q31(input logic signed [64:0] v);
    if (v > $signed({1'b0, Q31_MAX_EXT})) return Q31_MAX_EXT;
    else if (v < $signed({1'b1, Q31_MIN_EXT})) return Q31_MIN_EXT;
    else return v[63:0];
  endfunction

  function automatic logic [63:0] sat_q63(input logic signed [64:0] v);
    if (v[64] != v[63]) return v[64] ? Q63_MIN : Q63_MAX;
    else return v[63:0];
  endfunction

endpackage

/* File: design/lane_if.sv */
// Purpose: carries one Q15 multiplier lane between datapath and lane unit.
// Assumes: operands are signed halfwords.
// Notes:   frac is the doubled, clamped Q31 product; prod the raw integer one.
`timescale 1ns/100ps
interface lane_if;
  logic [15:0] a;
  logic [15:0] b;
  logic [31:0] frac;
  logic [31:0] prod;
  modport lane (input a, input b, output frac, output prod);
  modport user (output a, output b, input frac, input prod);
endinterface // lane_if

/* File: design/q15_lane_multiplier.sv */
// Purpose: one signed halfword multiplier with fractional doubling.
// Assumes: purely combinational; the caller registers the results.
// Notes:   -1.0 times -1.0 would wrap to -1.0 after doubling, so it is clamped.
`timescale 1ns/100ps
module q15_lane_multiplier
  import mac_pkg::*;
(
  lane_if.lane port
);

  logic signed [31:0] raw;

  // ==========================================================
  // integer product and its Q31 form
  assign raw = $signed(port.a) * $signed(port.b);
  assign port.prod = raw;
  always_comb begin
    if (port.a == Q15_MINUS_ONE && port.b == Q15_MINUS_ONE) begin
      port.frac = Q31_MAX;
    end else begin
      port.frac = {raw[30:0], 1'b0};
    end
  end

endmodule // q15_lane_multiplier

/* File: design/fractional_mac_subtract_datapath.sv */
// Purpose: multiply-accumulate/subtract datapath for Q15/Q31 operations,
//          holding the accumulators and driving a general-register write.
// Assumes: one operation per cycle, taken when op_valid is high.
// Notes:   results land one cycle after the operation is taken.
// Overview of operation
// - dot-subtract doubles both Q15 pair products
// - minus one squared clamps to Q31 max
// - sign-extend products, sum, subtract from accumulator
// - crossed subtract, accumulator not saturated
// - crossed subtract with saturated accumulator result
// - complex step: left minus right, accumulate
// - Q31 by Q31 into Q63, clamped
// - long accumulate saturates at accumulator limits
// - long subtract saturates at accumulator limits
// - single Q15 product added to accumulator
// - accumulate form saturates to Q31 limits
// - paired multiply keeps low 16 bits
// - saturating paired multiply clamps to 16 bits
`timescale 1ns/100ps
module fractional_mac_subtract_datapath
  import mac_pkg::*;
#(
  parameter int ACC_SEL_WIDTH = ACC_SEL_WIDTH_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire op_type op_code,
  input wire logic [ACC_SEL_WIDTH-1:0] accumulator_select,
  input wire logic [31:0] first_source_register,
  input wire logic [31:0] second_source_register,
  input wire logic [GPR_INDEX_WIDTH-1:0] dest_register,
  input wire logic [ACC_SEL_WIDTH-1:0] acc_read_select,
  output logic [63:0] acc_read_data,
  output logic acc_write_valid,
  output logic [ACC_SEL_WIDTH-1:0] acc_write_select,
  output logic gpr_write_valid,
  output logic [GPR_INDEX_WIDTH-1:0] gpr_write_index,
  output logic [31:0] gpr_write_data
);

  localparam int ACC_COUNT = 1 << ACC_SEL_WIDTH;

  // ==========================================================
  // elaboration checks
  if (ACC_SEL_WIDTH < 1 || ACC_SEL_WIDTH > 4) begin : g_bad_sel
    $error("accumulator select width must be 1 to 4");
  end

  logic [63:0] acc_q [ACC_COUNT];
  logic [63:0] acc_d;
  logic [31:0] gpr_data_d;
  logic crossed;
  logic acc_op;
  logic [63:0] cur_acc;
  logic [63:0] up_ext;
  logic [63:0] lo_ext;
  logic [63:0] long_raw;
  logic [63:0] long_q63;
  logic [64:0] acc_wide;
  logic [15:0] up_half;
  logic [15:0] lo_half;
  logic acc_write_valid_q;
  logic [ACC_SEL_WIDTH-1:0] acc_write_select_q;
  logic gpr_write_valid_q;
  logic [GPR_INDEX_WIDTH-1:0] gpr_write_index_q;
  logic [31:0] gpr_write_data_q;
  logic [63:0] acc_read_data_q;

  // ==========================================================
  // lane operand routing
  lane_if upper_lane ();
  lane_if lower_lane ();

  // crossed forms swap the halves of the second source
  assign crossed = (op_code == crossed_q15_dot_subtract) ||
                   (op_code == crossed_q15_dot_subtract_sat);
  assign upper_lane.a = first_source_register[31:UPPER_HALF_LSB];
  assign lower_lane.a = first_source_register[UPPER_HALF_LSB-1:0];
  assign upper_lane.b = crossed ? second_source_register[UPPER_HALF_LSB-1:0]
                                : second_source_register[31:UPPER_HALF_LSB];
  assign lower_lane.b = crossed ? second_source_register[31:UPPER_HALF_LSB]
                                : second_source_register[UPPER_HALF_LSB-1:0];

  q15_lane_multiplier u_upper_lane (
    .port(upper_lane.lane)
  );

  q15_lane_multiplier u_lower_lane (
    .port(lower_lane.lane)
  );

  // ==========================================================
  // shared operands for the accumulator arithmetic
  assign cur_acc = acc_q[accumulator_select];
  assign acc_wide = {cur_acc[63], cur_acc};
  assign up_ext = {{32{upper_lane.frac[31]}}, upper_lane.frac};
  assign lo_ext = {{32{lower_lane.frac[31]}}, lower_lane.frac};
  assign long_raw = $signed(first_source_register) * $signed(second_source_register);

  // the doubled Q63 product of -1.0 times -1.0 would wrap, so clamp it
  always_comb begin
    if (first_source_register == Q31_MINUS_ONE && second_source_register == Q31_MINUS_ONE) begin
      long_q63 = Q63_MAX;
    end else begin
      long_q63 = {long_raw[62:0], 1'b0};
    end
  end

  // paired multiply lanes, wrapped or clamped to 16 bits
  always_comb begin
    up_half = upper_lane.prod[15:0];
    lo_half = lower_lane.prod[15:0];
    if (op_code == paired_halfword_multiply_sat) begin
      if ($signed(upper_lane.prod) > $signed({{16{1'b0}}, H16_MAX})) up_half = H16_MAX;
      else if ($signed(upper_lane.prod) < $signed({{16{1'b1}}, H16_MIN})) up_half = H16_MIN;
      if ($signed(lower_lane.prod) > $signed({{16{1'b0}}, H16_MAX})) lo_half = H16_MAX;
      else if ($signed(lower_lane.prod) < $signed({{16{1'b1}}, H16_MIN})) lo_half = H16_MIN;
    end
    gpr_data_d = {up_half, lo_half};
  end

  // ==========================================================
  // next accumulator value per operation
  // the two Q31 products sum to at most 33 bits; the unsaturated forms can still wrap the 64-bit accumulator
  always_comb begin
    acc_op = 1'b1;
    acc_d = cur_acc;
    unique case (op_code)
      q15_dot_product_subtract,
      crossed_q15_dot_subtract: begin
        acc_d = cur_acc - (up_ext + lo_ext);
      end
      crossed_q15_dot_subtract_sat: begin
        acc_d = sat_q31(acc_wide - {up_ext[63], up_ext} - {lo_ext[63], lo_ext});
      end
      complex_multiply_step: begin
        acc_d = cur_acc + (up_ext - lo_ext);
      end
      long_fractional_mac_sat: begin
        acc_d = sat_q63(acc_wide + {long_q63[63], long_q63});
      end
      long_fractional_msub_sat: begin
        acc_d = sat_q63(acc_wide - {long_q63[63], long_q63});
      end
      fractional_mac_upper: begin
        acc_d = cur_acc + up_ext;
      end
      fractional_mac_lower: begin
        acc_d = cur_acc + lo_ext;
      end
      fractional_mac_upper_acc_sat: begin
        acc_d = sat_q31(acc_wide + {up_ext[63], up_ext});
      end
      fractional_mac_lower_acc_sat: begin
        acc_d = sat_q31(acc_wide + {lo_ext[63], lo_ext});
      end
      paired_halfword_multiply,
      paired_halfword_multiply_sat: begin
        acc_op = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // accumulator file: only the selected entry changes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < ACC_COUNT; i++) begin
        acc_q[i] <= ACC_RESET;
      end
    end else if (op_valid && acc_op) begin
      acc_q[accumulator_select] <= acc_d;
    end
  end

  // accumulator write report
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_write_valid_q <= 1'b0;
      acc_write_select_q <= '0;
    end else begin
      acc_write_valid_q <= op_valid && acc_op;
      acc_write_select_q <= accumulator_select;
    end
  end

  // general-register result, registered so it lines up with the accumulators
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gpr_write_valid_q <= 1'b0;
      gpr_write_index_q <= '0;
      gpr_write_data_q <= GPR_DATA_RESET;
    end else begin
      gpr_write_valid_q <= op_valid && !acc_op;
      if (op_valid && !acc_op) begin
        gpr_write_index_q <= dest_register;
        gpr_write_data_q <= gpr_data_d;
      end
    end
  end

  // readback port; one cycle behind the select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_read_data_q <= ACC_RESET;
    end else begin
      acc_read_data_q <= acc_q[acc_read_select];
    end
  end

  assign acc_read_data = acc_read_data_q;
  assign acc_write_valid = acc_write_valid_q;
  assign acc_write_select = acc_write_select_q;
  assign gpr_write_valid = gpr_write_valid_q;
  assign gpr_write_index = gpr_write_index_q;
  assign gpr_write_data = gpr_write_data_q;

  // ==========================================================
  // assertions: independent reference arithmetic
  function automatic logic [63:0] ref_q15(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == Q15_MINUS_ONE && b == Q15_MINUS_ONE) return Q31_MAX_EXT;
    return 64'($signed({p[30:0], 1'b0}));
  endfunction

  logic [63:0] r_uu;
  logic [63:0] r_ll;
  logic [63:0] r_ul;
  logic [63:0] r_lu;
  logic [64:0] r_long;
  assign r_uu = ref_q15(first_source_register[31:16], second_source_register[31:16]);
  assign r_ll = ref_q15(first_source_register[15:0], second_source_register[15:0]);
  assign r_ul = ref_q15(first_source_register[31:16], second_source_register[15:0]);
  assign r_lu = ref_q15(first_source_register[15:0], second_source_register[31:16]);
  // the plain doubled product of -1.0 squared sits one step past the Q63 limit
  always_comb begin
    r_long = 65'($signed(first_source_register) * $signed(second_source_register)) <<< 1;
    if (first_source_register == Q31_MINUS_ONE && second_source_register == Q31_MINUS_ONE) begin
      r_long = {1'b0, Q63_MAX};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  frac_clamp_a: assert property (
    upper_lane.a == Q15_MINUS_ONE && upper_lane.b == Q15_MINUS_ONE |-> upper_lane.frac == Q31_MAX)
    else $error("minus one squared not clamped");
  dot_subtract_a: assert property (
    op_valid && op_code == q15_dot_product_subtract
    |=> acc_q[$past(accumulator_select)] == $past(cur_acc - r_uu - r_ll))
    else $error("dot-product subtract result wrong");
  crossed_subtract_a: assert property (
    op_valid && op_code == crossed_q15_dot_subtract
    |=> acc_q[$past(accumulator_select)] == $past(cur_acc - r_ul - r_lu))
    else $error("crossed subtract result wrong");
  crossed_sat_a: assert property (
    op_valid && op_code == crossed_q15_dot_subtract_sat
    |=> acc_q[$past(accumulator_select)]
        == $past(sat_q31(acc_wide - {r_ul[63], r_ul} - {r_lu[63], r_lu})))
    else $error("crossed saturating subtract wrong");
  complex_step_a: assert property (
    op_valid && op_code == complex_multiply_step
    |=> acc_q[$past(accumulator_select)] == $past(cur_acc + r_uu - r_ll))
    else $error("complex step result wrong");
  long_mac_a: assert property (
    op_valid && op_code == long_fractional_mac_sat
    |=> acc_q[$past(accumulator_select)] == $past(sat_q63(acc_wide + r_long)))
    else $error("long accumulate result wrong");
  long_msub_a: assert property (
    op_valid && op_code == long_fractional_msub_sat
    && first_source_register == Q31_MINUS_ONE && second_source_register == Q31_MINUS_ONE
    |=> acc_q[$past(accumulator_select)] == $past(sat_q63(acc_wide - {1'b0, Q63_MAX})))
    else $error("long subtract clamp wrong");
  mac_lower_a: assert property (
    op_valid && op_code == fractional_mac_lower
    |=> acc_q[$past(accumulator_select)] == $past(cur_acc + r_ll))
    else $error("lower multiply-accumulate wrong");
  mac_sat_a: assert property (
    op_valid && op_code == fractional_mac_upper_acc_sat
    |=> acc_q[$past(accumulator_select)] == $past(sat_q31(acc_wide + {r_uu[63], r_uu})))
    else $error("saturating multiply-accumulate wrong");
  paired_mul_a: assert property (
    op_valid && op_code == paired_halfword_multiply
    |=> gpr_write_valid && gpr_write_index == $past(dest_register)
        && gpr_write_data == $past({
           16'($signed(first_source_register[31:16]) * $signed(second_source_register[31:16])),
           16'($signed(first_source_register[15:0]) * $signed(second_source_register[15:0]))}))
    else $error("paired multiply low halves wrong");
  paired_sat_a: assert property (
    op_valid && op_code == paired_halfword_multiply_sat
    && first_source_register == 32'h7FFF7FFF && second_source_register == 32'h7FFF8001
    |=> gpr_write_data == {H16_MAX, H16_MIN})
    else $error("paired multiply saturation wrong");
  acc_hold_a: assert property (
    op_valid && accumulator_select != acc_read_select
    |=> acc_q[$past(acc_read_select)] == $past(acc_q[acc_read_select]) && !gpr_write_valid ||
        $past(!acc_op))
    else $error("unselected accumulator changed");

  dot_sub_c: cover property (op_valid && op_code == q15_dot_product_subtract);
  long_sat_c: cover property (op_valid && op_code == long_fractional_mac_sat
    ##1 acc_q[$past(accumulator_select)] == Q63_MAX);
  paired_c: cover property (op_valid && op_code == paired_halfword_multiply_sat);
  complex_c: cover property (op_valid && op_code == complex_multiply_step ##1 op_valid);

endmodule // fractional_mac_subtract_datapath

/* File: testbench/decode_model.sv */
// Purpose: decode-stage and register-file stand-in that issues operations.
// Assumes: an operation starts at a falling edge and is held one full cycle.
// Notes:   idle source lines show the inverted last word, never a stale copy.
`timescale 1ns/100ps
module decode_model
  import mac_pkg::*;
(
  input wire logic clk,
  output logic op_valid,
  output op_type op_code,
  output logic [1:0] accumulator_select,
  output logic [31:0] first_source_register,
  output logic [31:0] second_source_register,
  output logic [4:0] dest_register
);
  // ============================================================
  // quiet lines at time zero
  initial begin
    op_valid = 1'b0;
    op_code = q15_dot_product_subtract;
    accumulator_select = 2'h0;
    first_source_register = 32'h0;
    second_source_register = 32'h0;
    dest_register = 5'h0;
  end

  // ============================================================
  // one operation; last low keeps valid up for a back-to-back follower
  task automatic issue(input op_type op, input logic [1:0] s, input logic [31:0] a,
                       input logic [31:0] b, input logic [4:0] rd, input logic last);
    op_valid = 1'b1;
    op_code = op;
    accumulator_select = s;
    first_source_register = a;
    second_source_register = b;
    dest_register = rd;
    @(negedge clk);
    if (last) begin
      // inverted words so a late sample cannot pass by luck
      op_valid = 1'b0;
      first_source_register = ~a;
      second_source_register = ~b;
    end
  endtask
endmodule // decode_model

/* File: testbench/tb_fractional_mac_subtract_datapath.sv */
// Purpose: self-checking bench for the fractional multiply-accumulate datapath.
// Assumes: one-cycle result latency, accumulators read back one cycle late.
// Notes:   expectations come from a private reference of the arithmetic.
`timescale 1ns/100ps
module tb_fractional_mac_subtract_datapath;
  import mac_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] acc_read_select = 2'h0;
  logic op_valid;
  op_type op_code;
  logic [1:0] accumulator_select;
  logic [31:0] first_source_register;
  logic [31:0] second_source_register;
  logic [4:0] dest_register;
  logic [63:0] acc_read_data;
  logic acc_write_valid;
  logic [1:0] acc_write_select;
  logic gpr_write_valid;
  logic [4:0] gpr_write_index;
  logic [31:0] gpr_write_data;
  logic [63:0] acc_m [4];
  int n_errors = 0;
  int samples_checked = 0;

  fractional_mac_subtract_datapath i_fractional_mac_subtract_datapath (.clk(clk),
    .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
    .accumulator_select(accumulator_select), .first_source_register(first_source_register),
    .second_source_register(second_source_register), .dest_register(dest_register),
    .acc_read_select(acc_read_select), .acc_read_data(acc_read_data),
    .acc_write_valid(acc_write_valid), .acc_write_select(acc_write_select),
    .gpr_write_valid(gpr_write_valid), .gpr_write_index(gpr_write_index),
    .gpr_write_data(gpr_write_data));
  decode_model i_decode_model (.clk(clk), .op_valid(op_valid), .op_code(op_code),
    .accumulator_select(accumulator_select), .first_source_register(first_source_register),
    .second_source_register(second_source_register), .dest_register(dest_register));

  // ============================================================
  // clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // ============================================================
  // reference arithmetic
  function automatic logic signed [64:0] sx(input logic [31:0] v);
    return {{33{v[31]}}, v};
  endfunction
  function automatic logic [31:0] fq(input logic [15:0] x, input logic [15:0] y);
    if (x == 16'h8000 && y == 16'h8000) return 32'h7FFFFFFF;
    return 32'($signed(x) * $signed(y)) << 1;
  endfunction
  function automatic logic [63:0] s31(input logic signed [64:0] v);
    if (v > 65'sh07FFFFFFF) return Q31_MAX_EXT;
    if (v < -65'sh080000000) return Q31_MIN_EXT;
    return v[63:0];
  endfunction
  function automatic logic [63:0] s63(input logic signed [64:0] v);
    if (v[64] != v[63]) return v[64] ? Q63_MIN : Q63_MAX;
    return v[63:0];
  endfunction
  function automatic logic [15:0] ph(input logic [15:0] x, input logic [15:0] y,
                                     input logic sat);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    if (sat && p > 32'sh00007FFF) return 16'h7FFF;
    if (sat && p < -32'sh00008000) return 16'h8000;
    return p[15:0];
  endfunction
  function automatic logic [63:0] ref_acc(input op_type op, input logic [63:0] acc,
                                          input logic [31:0] a, input logic [31:0] b);
    logic signed [64:0] ac;
    logic signed [64:0] st;
    logic signed [64:0] xs;
    logic signed [64:0] lp;
    logic signed [64:0] r;
    ac = $signed({acc[63], acc});
    st = sx(fq(a[31:16], b[31:16])) + sx(fq(a[15:0], b[15:0]));
    xs = sx(fq(a[31:16], b[15:0])) + sx(fq(a[15:0], b[31:16]));
    lp = $signed(a) * $signed(b);
    lp = (a == Q31_MINUS_ONE && b == Q31_MINUS_ONE) ? {1'b0, Q63_MAX} : lp <<< 1;
    case (op)
      q15_dot_product_subtract: r = ac - st;
      crossed_q15_dot_subtract: r = ac - xs;
      crossed_q15_dot_subtract_sat: r = s31(ac - xs);
      complex_multiply_step: r = ac + sx(fq(a[31:16], b[31:16])) - sx(fq(a[15:0], b[15:0]));
      long_fractional_mac_sat: r = s63(ac + lp);
      long_fractional_msub_sat: r = s63(ac - lp);
      fractional_mac_upper: r = ac + sx(fq(a[31:16], b[31:16]));
      fractional_mac_lower: r = ac + sx(fq(a[15:0], b[15:0]));
      fractional_mac_upper_acc_sat: r = s31(ac + sx(fq(a[31:16], b[31:16])));
      fractional_mac_lower_acc_sat: r = s31(ac + sx(fq(a[15:0], b[15:0])));
      default: r = ac;
    endcase
    return r[63:0];
  endfunction

  // ============================================================
  // comparison, readback and one checked operation
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic read_acc(input logic [1:0] s);
    acc_read_select = s;
    @(negedge clk);
    check("acc_read_data", acc_read_data, acc_m[s]);
  endtask
  task automatic run_op(input op_type op, input logic [1:0] s, input logic [31:0] a,
                        input logic [31:0] b, input logic [4:0] rd);
    logic pm;
    pm = (op == paired_halfword_multiply || op == paired_halfword_multiply_sat);
    i_decode_model.issue(op, s, a, b, rd, 1'b1);
    check("acc_write_valid", acc_write_valid, !pm);
    check("gpr_write_valid", gpr_write_valid, pm);
    if (pm) begin
      check("gpr_write_index", gpr_write_index, rd);
      check("gpr_write_data", gpr_write_data, {ph(a[31:16], b[31:16],
        op == paired_halfword_multiply_sat), ph(a[15:0], b[15:0],
        op == paired_halfword_multiply_sat)});
      check("gpr_data_lo", gpr_write_data[15:0], ph(a[15:0], b[15:0],
        op == paired_halfword_multiply_sat));
      // let an edge pass so the next issue never re-raises valid in this step
      @(negedge clk);
      check("gpr_write_valid", gpr_write_valid, 1'b0);
    end else begin
      check("acc_write_select", acc_write_select, s);
      acc_m[s] = ref_acc(op, acc_m[s], a, b);
      read_acc(s);
      check("acc_write_valid", acc_write_valid, 1'b0);
    end
  endtask

  // ============================================================
  // scenarios
  task automatic s_reset();
    for (int i = 0; i < 4; i++) begin
      acc_m[i] = ACC_RESET;
      read_acc(2'(i));
    end
  endtask
  task automatic s_dot();
    run_op(q15_dot_product_subtract, 2'h1, 32'h80004000, 32'h80002000, 5'h0);
    run_op(q15_dot_product_subtract, 2'h1, 32'hFFFF7FFF, 32'h00017FFF, 5'h0);
    run_op(complex_multiply_step, 2'h1, 32'h80003000, 32'h8000C000, 5'h0);
  endtask
  task automatic s_cross();
    run_op(crossed_q15_dot_subtract, 2'h2, 32'h12348000, 32'h80000100, 5'h0);
    run_op(crossed_q15_dot_subtract, 2'h2, 32'h80008000, 32'h80008000, 5'h0);
    run_op(crossed_q15_dot_subtract_sat, 2'h3, 32'h80008000, 32'h80008000, 5'h0);
    run_op(crossed_q15_dot_subtract_sat, 2'h3, 32'h00020003, 32'h00050007, 5'h0);
  endtask
  task automatic s_long();
    run_op(long_fractional_mac_sat, 2'h0, 32'h80000000, 32'h80000000, 5'h0);
    run_op(long_fractional_mac_sat, 2'h0, 32'h80000000, 32'h80000000, 5'h0);
    run_op(long_fractional_mac_sat, 2'h0, 32'h80000000, 32'h12345678, 5'h0);
    run_op(long_fractional_msub_sat, 2'h2, 32'h80000000, 32'h80000000, 5'h0);
    run_op(long_fractional_msub_sat, 2'h2, 32'h80000000, 32'h80000000, 5'h0);
  endtask
  task automatic s_mac();
    run_op(fractional_mac_upper, 2'h1, 32'h80001234, 32'h80007FFF, 5'h0);
    run_op(fractional_mac_lower, 2'h1, 32'h7FFF8000, 32'h12348000, 5'h0);
    run_op(fractional_mac_upper_acc_sat, 2'h3, 32'h80000001, 32'h80000001, 5'h0);
    run_op(fractional_mac_upper_acc_sat, 2'h3, 32'h80000001, 32'h80000001, 5'h0);
    run_op(fractional_mac_lower_acc_sat, 2'h0, 32'h00018000, 32'h00017FFF, 5'h0);
  endtask
  task automatic s_paired();
    run_op(paired_halfword_multiply, 2'h0, 32'h7FFFFFFE, 32'h00030005, 5'h07);
    run_op(paired_halfword_multiply_sat, 2'h0, 32'h7FFF8000, 32'h00038000, 5'h1F);
    run_op(paired_halfword_multiply_sat, 2'h0, 32'hFFFD0100, 32'h00060100, 5'h03);
    run_op(paired_halfword_multiply_sat, 2'h0, 32'h7FFF7FFF, 32'h7FFF8001, 5'h02);
  endtask
  task automatic s_chain();
    i_decode_model.issue(fractional_mac_lower, 2'h2, 32'h00001000, 32'h00004000, 5'h0, 1'b0);
    i_decode_model.issue(fractional_mac_lower, 2'h2, 32'h00002000, 32'h00004000, 5'h0, 1'b1);
    acc_m[2] = ref_acc(fractional_mac_lower, acc_m[2], 32'h00001000, 32'h00004000);
    acc_m[2] = ref_acc(fractional_mac_lower, acc_m[2], 32'h00002000, 32'h00004000);
    read_acc(2'h2);
  endtask
  task automatic s_rereset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    s_reset();
  endtask

  // ============================================================
  // verdict, one place for both endings
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence; the run needs about 70 cycles, so 20 us is a hang
  initial begin
    fork
      begin
        #20000;
        n_errors++;
        complete_run();
      end
    join_none
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    s_reset();
    s_dot();
    s_cross();
    s_long();
    s_mac();
    s_paired();
    s_chain();
    s_rereset();
    complete_run();
  end
endmodule // tb_fractional_mac_subtract_datapath
